/* File: countdown_counter.sv */
// error generation countdown counter, invisible to software
`timescale 1ns/1ps
module countdown_counter
   import fault_inject_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control side
   countdown_if.cnt  cd
);
   logic [CNT_W-1:0] count_q;   // current count
   logic [CNT_W-1:0] count_d;
   logic             hit_q;     // registered zero event
   logic             hit_d;

   // next count: load wins, then decrement on tick while enabled and nonzero
   always_comb
   begin
      count_d = count_q;
      hit_d   = 1'b0;
      if (cd.load)
      begin
         count_d = cd.reload;
      end
      else if (!cd.enable)
      begin
         count_d = count_q;
      end
      else if (cd.tick && (count_q != CNT_ZERO))
      begin
         if (count_q == CNT_ONE)
         begin
            hit_d   = 1'b1;
            count_d = cd.restart ? cd.reload : CNT_ZERO;
         end
         else
         begin
            count_d = count_q - CNT_ONE;
         end
      end
   end

   // register the count; a zero count after reset never fires
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= CNT_ZERO;
         hit_q   <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         hit_q   <= hit_d;
      end
   end

   assign cd.hit_zero = hit_q;
endmodule : countdown_counter

/* File: countdown_if.sv */
// carrier between the control logic and the error generation counter
`timescale 1ns/1ps
interface countdown_if;
   import fault_inject_pkg::*;
   logic             load;        // one-cycle load from reload value
   logic             enable;      // counter allowed to run
   logic             restart;     // reload on reaching zero
   logic             tick;        // counting clock enable
   logic [CNT_W-1:0] reload;      // countdown reload value
   logic             hit_zero;    // one-cycle pulse: decremented to zero

   modport ctl (output load, output enable, output restart, output tick,
                output reload, input hit_zero);
   modport cnt (input load, input enable, input restart, input tick,
                input reload, output hit_zero);
endinterface : countdown_if

/* File: fault_inject_ctl.sv */
// fault injection control register and injection sequencer for one node
`timescale 1ns/1ps
module fault_inject_ctl
   import fault_inject_pkg::*;
(
   // clock and resets
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              recovery_rst,
   // register port
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   output logic      [DATA_W-1:0] reg_rdata,
   // node configuration straps
   input  wire logic [1:0]        inject_support_field,
   input  wire logic              first_record,
   input  wire logic              feat_restart,
   input  wire logic              spontaneous_detect,
   input  wire logic              feat_misc_ctl,
   input  wire logic              feat_misc_always,
   input  wire logic              feat_addr_ctl,
   input  wire logic              feat_addr_always,
   input  wire logic [1:0]        feat_corrected,
   // component side
   input  wire logic              count_tick,
   input  wire logic              component_access,
   // injected error record
   output logic                   inject_valid,
   output err_class_t             inject_class,
   output logic      [1:0]        inject_ce_code,
   output logic                   misc_syndrome_valid,
   output logic                   addr_syndrome_valid,
   output logic                   poison_value,
   output logic                   reported_flag_value,
   output logic                   critical_flag_value,
   output logic                   overflow_value,
   output logic                   fault_state
);
   // limit a corrected select to what the node supports
   function automatic logic [1:0] ce_limit(input logic [1:0] sel, input logic [1:0] feat);
      logic [1:0] r;
      r = sel;
      if (feat == CE_OFF)
         r = CE_OFF;
      else if ((feat == CE_NONSPEC) && (sel != CE_NONSPEC))
         r = CE_OFF; // reserved values fall back to no injection
      return r;
   endfunction : ce_limit

   // status code recorded for a corrected select
   function automatic logic [1:0] ce_status(input logic [1:0] sel);
      logic [1:0] r;
      r = STS_CE_NONE;
      case (sel)
         CE_NONSPEC:   r = STS_CE_NONSP;
         CE_TRANSIENT: r = STS_CE_TRANS;
         CE_PERSIST:   r = STS_CE_PERS;
         default:      r = STS_CE_NONE;
      endcase
      return r;
   endfunction : ce_status

   countdown_if cd ();   // link to the counter

   // register presence
   logic present;
   assign present = (inject_support_field != INJ_NONE) && first_record;

   // stored control fields
   logic             cnt_en_q, cnt_en_d;     // countdown enable
   logic             restart_q, restart_d;   // restart on zero
   logic             msv_q, msv_d;           // misc valid value
   logic             asv_q, asv_d;           // address valid value
   logic             psn_q, psn_d;
   logic             rpt_q, rpt_d;
   logic             crit_q, crit_d;
   logic [1:0]       ce_q, ce_d;             // corrected select
   logic             dfr_q, dfr_d;
   logic             lat_q, lat_d;
   logic             rcv_q, rcv_d;
   logic             unr_q, unr_d;
   logic             unc_q, unc_d;
   logic             ovf_q, ovf_d;
   logic [CNT_W-1:0] reload_q, reload_d;     // countdown reload value
   logic             load_q, load_d;         // counter load strobe
   logic [DATA_W-1:0] rdata_q, rdata_d;      // read data
   logic             ctl_hit, rld_hit;
   logic             msv_rd, asv_rd;         // read-back of syndrome bits

   assign ctl_hit = present && (reg_addr == CTL_OFFSET);
   assign rld_hit = present && (reg_addr == RELOAD_OFFSET);
   // bits that always read one when the node forces them
   assign msv_rd  = feat_misc_always ? 1'b1 : (feat_misc_ctl & msv_q);
   assign asv_rd  = feat_addr_always ? 1'b1 : (feat_addr_ctl & asv_q);

   // register write decode and read mux
   always_comb
   begin
      cnt_en_d  = cnt_en_q;
      restart_d = restart_q;
      msv_d     = msv_q;
      asv_d     = asv_q;
      psn_d     = psn_q;
      rpt_d     = rpt_q;
      crit_d    = crit_q;
      ce_d      = ce_q;
      dfr_d     = dfr_q;
      lat_d     = lat_q;
      rcv_d     = rcv_q;
      unr_d     = unr_q;
      unc_d     = unc_q;
      ovf_d     = ovf_q;
      reload_d  = reload_q;
      load_d    = 1'b0;
      rdata_d   = rdata_q;
      if (reg_wr && ctl_hit)
      begin
         // reserved bits 63:32 and 29:13 are simply not stored
         cnt_en_d  = reg_wdata[CNT_EN_BIT];
         load_d    = reg_wdata[CNT_EN_BIT];
         restart_d = feat_restart & reg_wdata[RESTART_BIT];
         msv_d     = reg_wdata[MSV_BIT];
         asv_d     = reg_wdata[ASV_BIT];
         psn_d     = reg_wdata[PSN_BIT];
         rpt_d     = reg_wdata[RPT_BIT];
         crit_d    = reg_wdata[CRIT_BIT];
         ce_d      = ce_limit(reg_wdata[CE_HI:CE_LO], feat_corrected);
         dfr_d     = reg_wdata[DFR_BIT];
         lat_d     = reg_wdata[LAT_BIT];
         rcv_d     = reg_wdata[RCV_BIT];
         unr_d     = reg_wdata[UNR_BIT];
         unc_d     = reg_wdata[UNC_BIT];
         ovf_d     = reg_wdata[OVF_BIT];
      end
      else if (reg_wr && rld_hit)
      begin
         reload_d = reg_wdata[CNT_W-1:0];
      end
      if (recovery_rst)
      begin
         // other fields keep their values; syndrome values are lost
         msv_d = 1'b0;
         asv_d = 1'b0;
      end
      if (reg_rd)
      begin
         rdata_d = '0; // absent register and unmapped offsets read zero
         if (ctl_hit)
         begin
            rdata_d[CNT_EN_BIT]  = cnt_en_q;
            rdata_d[RESTART_BIT] = restart_q;
            rdata_d[MSV_BIT]     = msv_rd;
            rdata_d[ASV_BIT]     = asv_rd;
            rdata_d[PSN_BIT]     = psn_q;
            rdata_d[RPT_BIT]     = rpt_q;
            rdata_d[CRIT_BIT]    = crit_q;
            rdata_d[CE_HI:CE_LO] = ce_q;
            rdata_d[DFR_BIT]     = dfr_q;
            rdata_d[LAT_BIT]     = lat_q;
            rdata_d[RCV_BIT]     = rcv_q;
            rdata_d[UNR_BIT]     = unr_q;
            rdata_d[UNC_BIT]     = unc_q;
            rdata_d[OVF_BIT]     = ovf_q;
         end
         else if (rld_hit)
         begin
            rdata_d[CNT_W-1:0] = reload_q;
         end
      end
   end

   // control register flops; cold reset gives defined zeros everywhere
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_en_q  <= 1'b0;
         restart_q <= 1'b0;
         msv_q     <= 1'b0;
         asv_q     <= 1'b0;
         psn_q     <= 1'b0;
         rpt_q     <= 1'b0;
         crit_q    <= 1'b0;
         ce_q      <= CE_OFF;
         dfr_q     <= 1'b0;
         lat_q     <= 1'b0;
         rcv_q     <= 1'b0;
         unr_q     <= 1'b0;
         unc_q     <= 1'b0;
         ovf_q     <= 1'b0;
         reload_q  <= CNT_ZERO;
         load_q    <= 1'b0;
         rdata_q   <= '0;
      end
      else
      begin
         cnt_en_q  <= cnt_en_d;
         restart_q <= restart_d;
         msv_q     <= msv_d;
         asv_q     <= asv_d;
         psn_q     <= psn_d;
         rpt_q     <= rpt_d;
         crit_q    <= crit_d;
         ce_q      <= ce_d;
         dfr_q     <= dfr_d;
         lat_q     <= lat_d;
         rcv_q     <= rcv_d;
         unr_q     <= unr_d;
         unc_q     <= unc_d;
         ovf_q     <= ovf_d;
         reload_q  <= reload_d;
         load_q    <= load_d;
         rdata_q   <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // counter hookup; the load strobe follows the write by one cycle
   assign cd.load    = load_q;
   assign cd.enable  = cnt_en_q;
   assign cd.restart = restart_q;
   assign cd.tick    = count_tick;
   assign cd.reload  = reload_q;

   countdown_counter u_counter (
      .clk (clk),
      .rst (rst),
      .cd  (cd)
   );

   // injection sequencer
   inj_state_t  state_q, state_d;
   logic        fire;                 // generate the error now
   err_class_t  pick;                 // highest priority enabled class
   logic        valid_q, valid_d;
   err_class_t  class_q, class_d;
   logic [1:0]  cecode_q, cecode_d;
   logic [5:0]  flags_q, flags_d;     // misc, addr, poison, reported, critical, overflow

   // fixed priority, worst class first
   always_comb
   begin
      pick = ERR_NONE;
      if (unc_q)
         pick = ERR_UNCONTAINABLE;
      else if (unr_q)
         pick = ERR_UNRECOVERABLE;
      else if (rcv_q)
         pick = ERR_RECOVERABLE;
      else if (lat_q)
         pick = ERR_LATENT;
      else if (dfr_q)
         pick = ERR_DEFERRED;
      else if (ce_q != CE_OFF)
         pick = ERR_CORRECTED;
   end

   // spontaneous nodes fire at once, others on the next access
   assign fire = (state_q == ST_INJECT) && (spontaneous_detect || component_access);

   // next state and recorded values
   always_comb
   begin
      state_d  = state_q;
      valid_d  = 1'b0;
      class_d  = class_q;
      cecode_d = cecode_q;
      flags_d  = flags_q;
      case (state_q)
         ST_IDLE:
         begin
            if (cd.hit_zero)
               state_d = ST_INJECT;
         end
         ST_INJECT:
         begin
            if (fire)
            begin
               state_d  = ST_IDLE;
               valid_d  = (pick != ERR_NONE);
               class_d  = pick;
               cecode_d = (pick == ERR_CORRECTED) ? ce_status(ce_q) : STS_CE_NONE;
               flags_d  = {msv_rd, asv_rd, psn_q, rpt_q, crit_q, ovf_q};
            end
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // sequencer flops
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q  <= ST_IDLE;
         valid_q  <= 1'b0;
         class_q  <= ERR_NONE;
         cecode_q <= STS_CE_NONE;
         flags_q  <= '0;
      end
      else
      begin
         state_q  <= state_d;
         valid_q  <= valid_d;
         class_q  <= class_d;
         cecode_q <= cecode_d;
         flags_q  <= flags_d;
      end
   end

   // record outputs held until the next event; inject_valid is a one-cycle pulse
   assign inject_valid        = valid_q;
   assign inject_class        = class_q;
   assign inject_ce_code      = cecode_q;
   assign misc_syndrome_valid = flags_q[5];
   assign addr_syndrome_valid = flags_q[4];
   assign poison_value        = flags_q[3];
   assign reported_flag_value = flags_q[2];
   assign critical_flag_value = flags_q[1];
   assign overflow_value      = flags_q[0];
   assign fault_state         = (state_q == ST_INJECT);
endmodule : fault_inject_ctl

/* File: fault_inject_ctl_assertions.sv */
// port-level checker for the fault injection control block
`timescale 1ns/1ps
module fault_inject_ctl_assertions
   import fault_inject_pkg::*;
(
   // clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // register port
   input wire logic              reg_rd,
   input wire logic              reg_wr,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_rdata,
   // straps and component side
   input wire logic [1:0]        inject_support_field,
   input wire logic              first_record,
   input wire logic              feat_restart,
   input wire logic              feat_misc_ctl,
   input wire logic              feat_misc_always,
   input wire logic              feat_addr_ctl,
   input wire logic              feat_addr_always,
   input wire logic              spontaneous_detect,
   input wire logic              component_access,
   // injected error record
   input wire logic              inject_valid,
   input wire err_class_t        inject_class,
   input wire logic [1:0]        inject_ce_code,
   input wire logic              fault_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // control read while the register exists
   wire logic ctl_rd = reg_rd && reg_addr == CTL_OFFSET && inject_support_field != 2'h0
                       && first_record;

   a_rsvd_read_zero: assert property (reg_rd && reg_addr == CTL_OFFSET |=>
      reg_rdata[63:32] == 32'h0 && reg_rdata[29:13] == 17'h0) else $error("reserved bits set");
   a_absent_reads_zero: assert property (reg_rd && (inject_support_field == 2'h0
      || !first_record) |=> reg_rdata == 64'h0) else $error("absent register not zero");
   a_norestart_zero: assert property (ctl_rd && !feat_restart |=> !reg_rdata[30])
      else $error("restart bit set without support");
   a_misc_forced_one: assert property (ctl_rd && feat_misc_ctl && feat_misc_always
      |=> reg_rdata[MSV_BIT]) else $error("forced misc valid reads zero");
   a_addr_forced_one: assert property (ctl_rd && feat_addr_ctl && feat_addr_always
      |=> reg_rdata[ASV_BIT]) else $error("forced addr valid reads zero");
   a_inject_from_state: assert property (inject_valid |-> $past(fault_state) && !fault_state)
      else $error("injection outside fault state");
   a_spont_exit: assert property ($rose(fault_state) && spontaneous_detect |=> !fault_state)
      else $error("spontaneous injection late");
   a_access_wait: assert property (fault_state && !spontaneous_detect && !component_access
      && !reg_wr |=> fault_state) else $error("fired without access");
   a_ce_code_set: assert property (inject_valid && inject_class == ERR_CORRECTED
      |-> inject_ce_code != STS_CE_NONE) else $error("corrected error without code");
   a_ce_code_clear: assert property (inject_valid && inject_class != ERR_CORRECTED
      |-> inject_ce_code == STS_CE_NONE) else $error("code on uncorrected error");
   a_one_class: assert property (inject_valid |-> inject_class != ERR_NONE)
      else $error("injection without class");
   // main scenario reached
   c_inject: cover property (inject_valid);
endmodule : fault_inject_ctl_assertions

bind fault_inject_ctl fault_inject_ctl_assertions u_chk (
   .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .inject_support_field(inject_support_field),
   .first_record(first_record), .feat_restart(feat_restart), .feat_misc_ctl(feat_misc_ctl),
   .feat_misc_always(feat_misc_always), .feat_addr_ctl(feat_addr_ctl),
   .feat_addr_always(feat_addr_always), .spontaneous_detect(spontaneous_detect),
   .component_access(component_access), .inject_valid(inject_valid),
   .inject_class(inject_class), .inject_ce_code(inject_ce_code), .fault_state(fault_state));

/* File: fault_inject_pkg.sv */
// constants, field layout and types for the fault injection control block
package fault_inject_pkg;
   // register map
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 64;
   localparam int          CNT_W        = 32;
   localparam logic [11:0] CTL_OFFSET   = 12'h808;
   localparam logic [11:0] RELOAD_OFFSET = 12'h810;
   // control field positions
   localparam int          CNT_EN_BIT   = 31;
   localparam int          RESTART_BIT  = 30;
   localparam int          MSV_BIT      = 12;
   localparam int          ASV_BIT      = 11;
   localparam int          PSN_BIT      = 10;
   localparam int          RPT_BIT      = 9;
   localparam int          CRIT_BIT     = 8;
   localparam int          CE_HI        = 7;
   localparam int          CE_LO        = 6;
   localparam int          DFR_BIT      = 5;
   localparam int          LAT_BIT      = 4;
   localparam int          RCV_BIT      = 3;
   localparam int          UNR_BIT      = 2;
   localparam int          UNC_BIT      = 1;
   localparam int          OVF_BIT      = 0;
   // encodings
   localparam logic [1:0]  INJ_NONE     = 2'h0;
   localparam logic [1:0]  CE_OFF       = 2'h0;
   localparam logic [1:0]  CE_NONSPEC   = 2'h1;
   localparam logic [1:0]  CE_TRANSIENT = 2'h2;
   localparam logic [1:0]  CE_PERSIST   = 2'h3;
   localparam logic [1:0]  STS_CE_NONE  = 2'h0;
   localparam logic [1:0]  STS_CE_NONSP = 2'h2;
   localparam logic [1:0]  STS_CE_TRANS = 2'h1;
   localparam logic [1:0]  STS_CE_PERS  = 2'h3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

   // class of the error produced by one injection event
   typedef enum logic [2:0] {
      ERR_NONE          = 3'b000,
      ERR_UNCONTAINABLE = 3'b001,
      ERR_UNRECOVERABLE = 3'b010,
      ERR_RECOVERABLE   = 3'b011,
      ERR_LATENT        = 3'b100,
      ERR_DEFERRED      = 3'b101,
      ERR_CORRECTED     = 3'b110
   } err_class_t;

   // injection sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_INJECT  = 2'b01
   } inj_state_t;
endpackage : fault_inject_pkg

/* File: test_fault_inject_ctl.sv */
// self-checking bench for the fault injection control block
`timescale 1ns/1ps
module test_fault_inject_ctl;
   import fault_inject_pkg::*;
   localparam int     LOAD = 5;       // countdown reload used throughout
   logic              clk = 1'b0;     // 50 MHz clock
   logic              rst = 1'b1;     // cold reset
   logic              rec_rst = 1'b0; // error-recovery reset
   logic              wr = 1'b0;      // register strobes
   logic              rd = 1'b0;
   logic [ADDR_W-1:0] addr = 12'h000;
   logic [DATA_W-1:0] wdata = 64'h0;
   logic [DATA_W-1:0] rdata;
   logic [1:0]        sup = 2'h1;     // node straps
   logic              first = 1'b1;
   logic              f_rs = 1'b1;
   logic              spont = 1'b1;
   logic              m_ctl = 1'b1;
   logic              m_alw = 1'b0;
   logic              a_ctl = 1'b1;
   logic              a_alw = 1'b0;
   logic [1:0]        f_ce = 2'h3;
   logic              tick = 1'b1;    // counting enable and access
   logic              acc = 1'b0;
   logic              iv, fs;
   wire  [5:0]        rec;            // recorded flag copies, misc first
   err_class_t        ic;
   logic [1:0]        cc;
   logic [1:0]        ce;
   logic [5:0]        fl;
   logic [DATA_W-1:0] v;
   logic [1:0]        sts [4] = '{STS_CE_NONE, STS_CE_NONSP, STS_CE_TRANS, STS_CE_PERS};
   int                n;
   int                failures = 0;
   int                compares = 0;

   fault_inject_ctl dut (
      .clk(clk), .rst(rst), .recovery_rst(rec_rst), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .inject_support_field(sup),
      .first_record(first), .feat_restart(f_rs), .spontaneous_detect(spont),
      .feat_misc_ctl(m_ctl), .feat_misc_always(m_alw), .feat_addr_ctl(a_ctl),
      .feat_addr_always(a_alw), .feat_corrected(f_ce), .count_tick(tick),
      .component_access(acc), .inject_valid(iv), .inject_class(ic), .inject_ce_code(cc),
      .misc_syndrome_valid(rec[5]), .addr_syndrome_valid(rec[4]), .poison_value(rec[3]),
      .reported_flag_value(rec[2]), .critical_flag_value(rec[1]), .overflow_value(rec[0]),
      .fault_state(fs));

   // free-running clock
   initial
   begin
      forever #10 clk = ~clk;
   end

   // one comparison, four-state exact
   task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one-cycle write strobe, entered at a falling edge
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge clk);
      wr    = 1'b0;
   endtask : wreg

   // read: data is registered on the same edge that takes the strobe
   task automatic creg(input string what, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp);
      addr = a;
      rd   = 1'b1;
      @(negedge clk);
      rd   = 1'b0;
      @(negedge clk);
      chk(what, rdata, exp);
   endtask : creg

   // load and start the countdown, count edges until an injection shows
   task automatic fire(input logic [DATA_W-1:0] d, input int lim, output int cyc);
      wreg(RELOAD_OFFSET, 64'(LOAD));
      wreg(CTL_OFFSET, d);
      cyc = 0;
      do
      begin
         @(negedge clk);
         cyc++;
      end
      while (iv !== 1'b1 && cyc < lim);
   endtask : fire

   // count injection pulses over a span
   task automatic quiet(input int span, output int hits);
      hits = 0;
      repeat (span)
      begin
         @(negedge clk);
         hits += (iv === 1'b1) ? 1 : 0;
      end
   endtask : quiet

   // verdict, reached from the tests and from the watchdog
   task automatic results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   // watchdog: the tests need well under a thousand cycles
   initial
   begin
      #(20 * 5000);
      failures++;
      results();
   end

   initial
   begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      creg("ctl cold", CTL_OFFSET, 64'h0);
      wreg(CTL_OFFSET, 64'hFFFF_FFFF_7FFF_FFFF);
      creg("ctl rw", CTL_OFFSET, 64'h0000_0000_4000_1FFF);
      creg("unmapped", 12'h800, 64'h0);
      // restart unsupported, corrected limited, syndrome flags forced
      f_rs  = 1'b0;
      f_ce  = 2'h1;
      m_alw = 1'b1;
      a_alw = 1'b1;
      wreg(CTL_OFFSET, 64'h0000_0000_4000_0080);
      creg("ctl limited", CTL_OFFSET, 64'h0000_0000_0000_1800);
      f_rs  = 1'b1;
      f_ce  = 2'h3;
      m_alw = 1'b0;
      a_alw = 1'b0;
      // register absent: no support, then not the first record
      for (int i = 0; i < 2; i++)
      begin
         sup   = (i == 0) ? 2'h0 : 2'h1;
         first = (i != 0) ? 1'b0 : 1'b1;
         wreg(CTL_OFFSET, 64'h0000_0000_0000_003E);
         creg("absent", CTL_OFFSET, 64'h0);
      end
      sup   = 2'h2;
      first = 1'b1;
      $display("test registers done");
      // priority ladder then every corrected encoding
      for (int j = 1; j < 9; j++)
      begin
         ce = (j < 6) ? 2'h3 : 2'(j - 5);
         fl = (j % 2 != 0) ? 6'h2A : 6'h15;
         v  = (64'h1 << CNT_EN_BIT) | (64'(fl[5:1]) << CRIT_BIT) | 64'(fl[0])
              | (64'(ce) << CE_LO) | ((j < 6) ? (64'h3E >> j << j) : 64'h0);
         fire(v, 40, n);
         chk("fire delay", 64'(n), 64'(LOAD + 3));
         chk("class", 64'(ic), (j < 6) ? 64'(j) : 64'(ERR_CORRECTED));
         chk("ce code", 64'(cc), 64'(sts[(j < 6) ? 0 : ce]));
         chk("flags", 64'(rec), 64'(fl));
      end
      quiet(60, n);
      chk("stopped", 64'(n), 64'h0);
      $display("test injection done");
      wreg(CTL_OFFSET, (64'h1 << CNT_EN_BIT) | (64'h1 << RESTART_BIT) | 64'h2);
      quiet(60, n);
      chk("restarts", 64'(n > 3), 64'h1);
      wreg(CTL_OFFSET, (64'h1 << CNT_EN_BIT) | 64'h2);
      wreg(CTL_OFFSET, 64'h2);
      // a zero reached just before the stop may still fire; let it drain
      repeat (4) @(negedge clk);
      quiet(40, n);
      chk("disabled", 64'(n), 64'h0);
      fire(64'h1 << CNT_EN_BIT, 20, n);
      chk("no class", 64'(n), 64'd20);
      tick = 1'b0;
      fire((64'h1 << CNT_EN_BIT) | 64'h2, 30, n);
      chk("no tick", 64'(n), 64'd30);
      tick = 1'b1;
      // access-triggered detection waits for the component
      spont = 1'b0;
      fire((64'h1 << CNT_EN_BIT) | 64'h2, 30, n);
      chk("wait access", 64'(n), 64'd30);
      chk("fault state", 64'(fs), 64'h1);
      acc = 1'b1;
      @(negedge clk);
      chk("access fire", 64'(iv), 64'h1);
      acc = 1'b0;
      spont = 1'b1;
      $display("test counter done");
      // recovery keeps control, drops stored syndrome valids
      wreg(CTL_OFFSET, 64'h0000_0000_C000_1FC1);
      rec_rst = 1'b1;
      @(negedge clk);
      rec_rst = 1'b0;
      creg("recovery", CTL_OFFSET, 64'h0000_0000_C000_07C1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      creg("cold again", CTL_OFFSET, 64'h0);
      $display("test resets done");
      results();
   end
endmodule : test_fault_inject_ctl
